/* hdl/kpi_keypad_irq_unit.sv */
// keypad interrupt unit top: apb registers, pad controls, cpu request
// assumes a synchronous apb master on clk and pins asynchronous to it
`timescale 1ns/10ps
`default_nettype none
`include "kpi_params.svh"
module kpi_keypad_irq_unit
   import kpi_pkg::*;
#(
   parameter int NPINS = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // keypad pins and pad controls
   input  wire logic [NPINS-1:0] keyPin,
   output logic      [NPINS-1:0] pullUpEn,
   output logic      [NPINS-1:0] pullDownEn,
   // cpu side
   input  wire logic             vectorFetch,
   output logic                  keypadIrq,
   output logic                  wakeUp,
   output logic                  irq
);
   // elaboration check: pin vectors must fit one 32-bit register word
   if (NPINS < 1 || NPINS > 32) begin : g_npinsBad
      $error("NPINS must be 1..32");
   end

   // software state
   logic [NPINS-1:0] pinEnable_q;   // pin_enable_register
   logic [NPINS-1:0] pinPolar_q;    // pin_polarity_register
   logic             levelSel_q;    // level_sensitivity_select
   logic             irqMask_q;     // keypad_irq_mask
   logic [`KPI_EV_W-1:0] evStat_q;  // sticky event status
   logic [`KPI_EV_W-1:0] evMask_q;  // event interrupt mask
   logic             pending;       // latch state from core
   logic             edgeSeen;      // qualifying edge pulse

   // bus decode
   wire logic        wrEn     = psel & penable & pwrite;
   wire logic        rdEn     = psel & penable & ~pwrite;
   wire logic        hitScr   = (paddr == `KPI_OFS_SCR);
   wire logic        hitEn    = (paddr == `KPI_OFS_ENABLE);
   wire logic        hitPol   = (paddr == `KPI_OFS_POLAR);
   wire logic        hitStat  = (paddr == `KPI_OFS_STATUS);
   wire logic        hitMsk   = (paddr == `KPI_OFS_IMASK);
   wire logic        hitPins  = (paddr == `KPI_OFS_PINS);
   wire logic        mapped   = hitScr | hitEn | hitPol | hitStat | hitMsk | hitPins;
   // software acknowledge strobe, one cycle
   wire logic        swAck    = wrEn & hitScr & pwdata[`KPI_SCR_ACK];
   wire logic        ack      = swAck | vectorFetch;
   wire kpi_mode_e   mode     = levelSel_q ? KPI_EDGE_LEVEL : KPI_EDGE_ONLY;
   wire logic [`KPI_EV_W-1:0] evSet = {edgeSeen, edgeSeen & ~pending};

   kpi_pin_if #(.NPINS(NPINS)) pinBus ();

   kpi_pin_sync #(.NPINS(NPINS)) uSync (
      .clk      (clk),
      .rst      (rst),
      .pinRaw   (keyPin),
      .polarity (pinPolar_q),
      .pins     (pinBus)
   );

   kpi_irq_latch #(.NPINS(NPINS)) uLatch (
      .clk      (clk),
      .rst      (rst),
      .enable   (pinEnable_q),
      .mode     (mode),
      .ack      (ack),
      .pins     (pinBus),
      .pending  (pending),
      .edgeSeen (edgeSeen)
   );

   // read mux
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (hitScr) begin
         rdMux[`KPI_SCR_MODE] = levelSel_q;
         rdMux[`KPI_SCR_MASK] = irqMask_q;
         rdMux[`KPI_SCR_PEND] = pending;
      end
      if (hitEn)   rdMux[NPINS-1:0]     = pinEnable_q;
      if (hitPol)  rdMux[NPINS-1:0]     = pinPolar_q;
      if (hitStat) rdMux[`KPI_EV_W-1:0] = evStat_q;
      if (hitMsk)  rdMux[`KPI_EV_W-1:0] = evMask_q;
      if (hitPins) rdMux[NPINS-1:0]     = pinBus.asserted;
   end

   // control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         pinEnable_q <= '0;
         pinPolar_q  <= '0;
         levelSel_q  <= 1'b0;
         irqMask_q   <= 1'b0;
         evMask_q    <= '0;
      end else if (wrEn) begin
         if (hitEn)  pinEnable_q <= pwdata[NPINS-1:0];
         if (hitPol) pinPolar_q  <= pwdata[NPINS-1:0];
         if (hitScr) begin
            levelSel_q <= pwdata[`KPI_SCR_MODE];
            irqMask_q  <= pwdata[`KPI_SCR_MASK];
         end
         if (hitMsk) evMask_q <= pwdata[`KPI_EV_W-1:0];
      end
   end

   // sticky event status, set wins over write-one-clear
   always_ff @(posedge clk) begin
      if (rst) begin
         evStat_q <= '0;
      end else begin
         evStat_q <= evSet | (evStat_q & ~((wrEn & hitStat) ? pwdata[`KPI_EV_W-1:0] : '0));
      end
   end

   // apb answer: one access cycle, zero wait
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped & `KPI_SLV_ERR;
         prdata  <= (psel & ~penable & ~pwrite) ? rdMux : 32'h0000_0000;
      end
   end

   // outputs, all registered
   always_ff @(posedge clk) begin
      if (rst) begin
         pullUpEn   <= '0;
         pullDownEn <= '0;
         keypadIrq  <= 1'b0;
         wakeUp     <= 1'b0;
         irq        <= 1'b0;
      end else begin
         pullUpEn   <= pinEnable_q & ~pinPolar_q;
         pullDownEn <= pinEnable_q & pinPolar_q;
         keypadIrq  <= pending & ~irqMask_q;
         wakeUp     <= pending & ~irqMask_q;
         irq        <= |(evStat_q & evMask_q);
      end
   end

   a_mask_gates : assert property (@(posedge clk) disable iff (rst)
      irqMask_q |=> !keypadIrq)
      else $error("request forwarded while masked");
   a_pull_select : assert property (@(posedge clk) disable iff (rst)
      ##1 (pullUpEn == ($past(pinEnable_q) & ~$past(pinPolar_q))))
      else $error("pull device mismatch");
   a_wake_follows : assert property (@(posedge clk) disable iff (rst)
      (pending && !irqMask_q) |=> wakeUp)
      else $error("wake not raised");
   a_sw_ack_clear : assert property (@(posedge clk) disable iff (rst)
      (swAck && !levelSel_q && !edgeSeen) |=> !pending)
      else $error("software acknowledge did not clear");
   a_ready_once : assert property (@(posedge clk) disable iff (rst)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready timing wrong");
endmodule : kpi_keypad_irq_unit
`default_nettype wire

/* hdl/kpi_params.svh */
// constants for the keypad interrupt unit: register map, fields, reset values
// assumes inclusion by bare name from the package and the design modules
// Behaviour
// - each pin has its own detect enable
// - polarity bit: 0 falling/low, 1 rising/high
// - global bit picks edge-only or edge-and-level
// - enabled pin gets pullup or pulldown by polarity
// - any enabled input asserting sets shared latch
// - edge-only: no latch while another input asserted
// - level mode: request holds while input asserted
// - level mode clears after deassert and acknowledge
// - deassert and acknowledge accepted in either order
// - vector fetch acknowledge clears the latch
// - writing acknowledge bit clears latch like fetch
// - edges after acknowledge latch a fresh request
// - request reaches cpu only while mask clear
// - reset clears request and sensitivity bit
// - edge-only: acknowledge clears latch at once
`ifndef KPI_PARAMS_SVH
`define KPI_PARAMS_SVH

// register byte offsets
`define KPI_OFS_SCR     12'h000
`define KPI_OFS_ENABLE  12'h004
`define KPI_OFS_POLAR   12'h008
`define KPI_OFS_STATUS  12'h00C
`define KPI_OFS_IMASK   12'h010
`define KPI_OFS_PINS    12'h014

// status/control register fields
`define KPI_SCR_MODE    0
`define KPI_SCR_MASK    1
`define KPI_SCR_ACK     2
`define KPI_SCR_PEND    3

// event status fields
`define KPI_EV_LATCH    0
`define KPI_EV_EDGE     1
`define KPI_EV_W        2

// reset values, slave error enable, address width
`define KPI_RST_SCR     32'h0000_0000
`define KPI_RST_IMASK   32'h0000_0000
`define KPI_SLV_ERR     1'b1
`define KPI_ADDR_W      12

`endif

/* hdl/kpi_pkg.sv */
// types shared by the keypad interrupt unit modules
// assumes kpi_params.svh is on the include path
`include "kpi_params.svh"
package kpi_pkg;
   typedef logic [`KPI_ADDR_W-1:0] kpi_addr_t;  // apb byte address
   typedef enum logic {
      KPI_EDGE_ONLY,
      KPI_EDGE_LEVEL
   } kpi_mode_e;                                // sensitivity choice
endpackage : kpi_pkg

/* hdl/kpi_pin_if.sv */
// bundle between the pin front end and the interrupt core
// assumes one clock; all members are clocked in the pin front end
`timescale 1ns/10ps
`default_nettype none
interface kpi_pin_if #(parameter int NPINS = 8);
   logic [NPINS-1:0] asserted;   // synchronised pin, polarity applied
   logic [NPINS-1:0] rise;       // new assertion seen this cycle
   modport front (output asserted, output rise);
   modport core  (input asserted, input rise);
endinterface : kpi_pin_if
`default_nettype wire

/* hdl/kpi_pin_sync.sv */
// pin front end: three-stage synchroniser, polarity, assertion edge
// assumes raw pins are asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module kpi_pin_sync
   import kpi_pkg::*;
#(
   parameter int NPINS = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // raw pins and polarity
   input  wire logic [NPINS-1:0] pinRaw,
   input  wire logic [NPINS-1:0] polarity,
   // to core
   kpi_pin_if.front              pins
);
   logic [NPINS-1:0] s1_q;        // first stage, read only by s2
   logic [NPINS-1:0] s2_q;        // second stage
   logic [NPINS-1:0] s3_q;        // third stage
   logic [NPINS-1:0] stable_q;    // agreed pin level
   logic [NPINS-1:0] assertNow;   // level with polarity applied

   // a change counts once stage two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q     <= '0;
         s2_q     <= '0;
         s3_q     <= '0;
         stable_q <= '0;
      end else begin
         s1_q     <= pinRaw;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
      end
   end

   // polarity 1 = high/rising, 0 = low/falling
   assign assertNow = ~(stable_q ^ polarity);

   // edge detect on the asserted level
   logic [NPINS-1:0] prev_q;      // last asserted level
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q        <= '1;    // seen as asserted: no false edge after reset
         pins.asserted <= '0;
         pins.rise     <= '0;
      end else begin
         prev_q        <= assertNow;
         pins.asserted <= assertNow;
         pins.rise     <= assertNow & ~prev_q;
      end
   end
endmodule : kpi_pin_sync
`default_nettype wire

/* hdl/kpi_irq_latch.sv */
// shared keypad latch with edge-only and edge-and-level clearing
// assumes pin events already synchronised and polarity applied
`timescale 1ns/10ps
`default_nettype none
module kpi_irq_latch
   import kpi_pkg::*;
#(
   parameter int NPINS = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic [NPINS-1:0] enable,
   input  wire kpi_mode_e        mode,
   input  wire logic             ack,
   // pin events
   kpi_pin_if.core               pins,
   // result
   output logic                  pending,
   output logic                  edgeSeen
);
   logic             latch_q;     // shared request latch
   logic             latch_d;
   logic             ackHeld_q;   // level mode: acknowledge taken while a pin still held
   logic             ackHeld_d;
   logic [NPINS-1:0] enAsserted;  // enabled pins at asserted level
   logic [NPINS-1:0] enRise;      // enabled pins newly asserted
   logic             othersHeld;  // some enabled pin already asserted
   logic             newEdge;     // qualifying edge this cycle
   logic             anyLevel;    // level mode and any enabled pin asserted

   assign enAsserted = pins.asserted & enable;
   assign enRise     = pins.rise & enable;
   assign othersHeld = |(enAsserted & ~enRise);
   // edge-only blocks an edge while another pin is held
   assign newEdge    = (|enRise) & ((mode == KPI_EDGE_LEVEL) | ~othersHeld);
   assign anyLevel   = (mode == KPI_EDGE_LEVEL) & (|enAsserted);
   // an acknowledge met while a held pin keeps the request alive is remembered,
   // so release and acknowledge may come in either order; a new edge forgets it
   assign ackHeld_d  = (ack | ackHeld_q) & anyLevel & ~newEdge;
   // set wins over acknowledge; level keeps request alive
   assign latch_d    = newEdge | anyLevel | (latch_q & ~ack & ~ackHeld_q);
   assign pending    = latch_q;
   assign edgeSeen   = newEdge;

   // latch update
   always_ff @(posedge clk) begin
      if (rst) begin
         latch_q   <= 1'b0;
         ackHeld_q <= 1'b0;
      end else begin
         latch_q   <= latch_d;
         ackHeld_q <= ackHeld_d;
      end
   end

   a_level_holds : assert property (@(posedge clk) disable iff (rst)
      (mode == KPI_EDGE_LEVEL && |enAsserted) |=> latch_q)
      else $error("request dropped while enabled pin asserted");
   a_edge_ack_clear : assert property (@(posedge clk) disable iff (rst)
      (mode == KPI_EDGE_ONLY && ack && !newEdge) |=> !latch_q)
      else $error("edge-only acknowledge did not clear latch");
   a_edge_sets : assert property (@(posedge clk) disable iff (rst)
      (|(pins.rise & enable) && !othersHeld) |=> latch_q)
      else $error("enabled edge did not set latch");
   a_edge_blocked : assert property (@(posedge clk) disable iff (rst)
      (mode == KPI_EDGE_ONLY && !latch_q && othersHeld && !ack) |=> !latch_q)
      else $error("edge latched while another pin held");
   a_hold_noack : assert property (@(posedge clk) disable iff (rst)
      (latch_q && !ack && !ackHeld_q) |=> latch_q)
      else $error("latch cleared without acknowledge");
   a_ack_remembered : assert property (@(posedge clk) disable iff (rst)
      (latch_q && ackHeld_q && !anyLevel && !newEdge) |=> !latch_q)
      else $error("earlier acknowledge lost after release");
endmodule : kpi_irq_latch
`default_nettype wire

/* sim/kpi_key_model.sv */
// keypad switch model: closed switches drive a level, open pins float to the pad pull
// assumes pull enables come from the unit; an unpulled open pin wanders every cycle
`timescale 1ns/10ps
`default_nettype none
module kpi_key_model #(
   parameter int NPINS = 8
) (
   // clock
   input  wire logic             clk,
   // switch state from the bench
   input  wire logic [NPINS-1:0] closed,
   input  wire logic [NPINS-1:0] level,
   // pad pulls from the unit
   input  wire logic [NPINS-1:0] pullUpEn,
   input  wire logic [NPINS-1:0] pullDownEn,
   // resolved pin levels
   output logic      [NPINS-1:0] keyPin
);
   logic [NPINS-1:0] wander_q = '0;  // changing pattern for pins nobody holds

   // free pattern so an undriven pin never looks stable
   always @(posedge clk) begin
      wander_q <= ~wander_q;
   end

   // switch wins, else the pull, else the wandering pattern
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (closed[i]) keyPin[i] = level[i];
         else if (pullUpEn[i]) keyPin[i] = 1'b1;
         else if (pullDownEn[i]) keyPin[i] = 1'b0;
         else keyPin[i] = wander_q[i];
      end
   end
endmodule // kpi_key_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the keypad interrupt unit, driven over apb
// assumes the unit answers each apb access with one pready cycle
`timescale 1ns/10ps
`default_nettype none
`include "kpi_params.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb;
   import kpi_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, vectorFetch;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  keyPin, pullUpEn, pullDownEn, closed;
   logic        keypadIrq, wakeUp, irq;
   int          mismatches, samplesChecked, cycles;
   logic [7:0]  assertLvl = 8'h06;  // level each switch drives when closed

   // unit under test
   kpi_keypad_irq_unit #(.NPINS(8)) kpi_keypad_irq_unit_i (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .keyPin(keyPin), .pullUpEn(pullUpEn),
      .pullDownEn(pullDownEn), .vectorFetch(vectorFetch), .keypadIrq(keypadIrq),
      .wakeUp(wakeUp), .irq(irq));
   // switches on the pins
   kpi_key_model #(.NPINS(8)) kpi_key_model_i (.clk(clk), .closed(closed), .level(assertLvl),
      .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .keyPin(keyPin));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      `CHK("prdata", exp, q)
      `CHK("pslverr", expErr, e)
   endtask

   // wait a bounded time for the cpu request to reach a level
   task automatic waitIrq(input logic e);
      int n;
      n = 0;
      while (keypadIrq !== e && n < 15) begin
         @(posedge clk);
         n++;
      end
      `CHK("keypadIrq", e, keypadIrq)
   endtask

   task automatic keys(input logic [7:0] c);
      @(posedge clk);
      closed <= c;
   endtask

   task automatic holdOff();
      repeat (10) @(posedge clk);
      `CHK("keypadIrq", 1'b0, keypadIrq)
   endtask

   task automatic fetch();
      @(posedge clk);
      vectorFetch <= 1'b1;
      @(posedge clk);
      vectorFetch <= 1'b0;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", samplesChecked, mismatches);
      if (mismatches == 0 && samplesChecked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; vectorFetch = 1'b0; closed = 8'h00;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`KPI_OFS_SCR, `KPI_RST_SCR, 1'b0);
      rd(12'h040, 32'h0000_0000, 1'b1);
      wr(`KPI_OFS_POLAR, 32'h0000_0006);
      wr(`KPI_OFS_ENABLE, 32'h0000_0003);
      wr(`KPI_OFS_SCR, 32'h0000_0004);
      wr(`KPI_OFS_STATUS, 32'h0000_0003);
      rd(`KPI_OFS_ENABLE, 32'h0000_0003, 1'b0);
      repeat (2) @(posedge clk);
      `CHK("pullUpEn", 8'h01, pullUpEn)
      `CHK("pullDownEn", 8'h02, pullDownEn)
      wr(`KPI_OFS_IMASK, 32'h0000_0001);
      keys(8'h01);
      waitIrq(1'b1);
      `CHK("irq", 1'b1, irq)
      rd(`KPI_OFS_STATUS, 32'h0000_0003, 1'b0);
      rd(`KPI_OFS_SCR, 32'h0000_0008, 1'b0);
      wr(`KPI_OFS_SCR, 32'h0000_0002);
      waitIrq(1'b0);
      `CHK("wakeUp", 1'b0, wakeUp)
      wr(`KPI_OFS_SCR, 32'h0000_0000);
      waitIrq(1'b1);
      `CHK("wakeUp", 1'b1, wakeUp)
      wr(`KPI_OFS_STATUS, 32'h0000_0003);
      repeat (2) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      wr(`KPI_OFS_SCR, 32'h0000_0004);
      waitIrq(1'b0);
      keys(8'h03);
      holdOff();
      keys(8'h00);
      holdOff();
      keys(8'h02);
      waitIrq(1'b1);
      fetch();
      waitIrq(1'b0);
      keys(8'h04);
      holdOff();
      keys(8'h00);
      wr(`KPI_OFS_SCR, 32'h0000_0001);
      keys(8'h01);
      waitIrq(1'b1);
      fetch();
      repeat (10) @(posedge clk);
      `CHK("keypadIrq", 1'b1, keypadIrq)
      keys(8'h00);
      waitIrq(1'b0);
      keys(8'h01);
      waitIrq(1'b1);
      keys(8'h00);
      repeat (10) @(posedge clk);
      `CHK("keypadIrq", 1'b1, keypadIrq)
      wr(`KPI_OFS_SCR, 32'h0000_0005);
      waitIrq(1'b0);
      keys(8'h01);
      waitIrq(1'b1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      `CHK("keypadIrq", 1'b0, keypadIrq)
      rd(`KPI_OFS_SCR, `KPI_RST_SCR, 1'b0);
      wr(`KPI_OFS_ENABLE, 32'h0000_0001);
      holdOff();
      results();
   end
endmodule // tb
`default_nettype wire
